// ### core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_START = 8'h04;
   localparam logic [7:0] OFF_RESULT = 8'h08;
   localparam logic [7:0] OFF_IRQ_REQ = 8'h0c;
   localparam logic [7:0] OFF_IRQ_EN = 8'h10;
   localparam logic [7:0] OFF_PORT_MODE = 8'h14;
   localparam logic [7:0] OFF_EDGE_SEL = 8'h18;

   // ****************************************
   // Field positions and widths
   // ****************************************
   localparam int MODE_CH_LSB = 0;
   localparam int MODE_CH_W = 4;
   localparam int MODE_TIME_BIT = 4;
   localparam int MODE_TRIGGER_ENABLE_BIT_BIT = 5;
   localparam int START_FLAG_BIT = 7;
   localparam int IRQ_CONV_BIT = 0;
   localparam int PORT_TRIG_BIT = 0;
   localparam int EDGE_TRIG_BIT = 0;
   localparam int RESULT_W = 10;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] PORT_MODE_RST = 8'h00;
   localparam logic [7:0] EDGE_SEL_RST = 8'h00;
   localparam logic [15:0] STEP_SHORT = 16'h0004;
   localparam logic [15:0] STEP_LONG = 16'h0008;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_APPROX = 3'b100
   } conv_state_e;

   typedef struct packed
   {
      logic [3:0] channel;
      logic long_time;
      logic trig_en;
   } mode_s;

endpackage

// ### core/sar_step.sv
`timescale 1ns/100ps
module sar_step
   import adc_ctrl_pkg::*;
#(
   parameter int W = RESULT_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic step,
   input wire logic cmp_hi,
   // State
   output logic [W-1:0] trial,
   output logic [W-1:0] bit_mask,
   output logic last
);

   // ****************************************
   // Successive approximation register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trial <= '0;
         bit_mask <= '0;
      end
      else if (load)
      begin
         bit_mask <= {1'b1, {(W-1){1'b0}}};
         trial <= {1'b1, {(W-1){1'b0}}};
      end
      else if (step)
      begin
         bit_mask <= bit_mask >> 1;
         trial <= (cmp_hi ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
      end
   end

   assign last = bit_mask[0];

endmodule

// ### core/adc_conversion_control.sv
`timescale 1ns/100ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
#(
   parameter int W = RESULT_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog front end
   input wire logic cmp_hi,
   output logic [3:0] channel_sel,
   output logic sample_en,
   output logic [W-1:0] dac_trial,
   // Trigger and interrupt
   input wire logic ext_trigger_pin,
   output logic irq
);

   // ****************************************
   // Declarations
   // ****************************************
   mode_s mode_r;
   logic [7:0] port_mode_reg_one_r;
   logic [7:0] edge_select_reg_r;
   logic conv_start_flag_r;
   logic conv_irq_request_flag_r;
   logic conv_irq_enable_bit_r;
   logic [W-1:0] result_r;
   conv_state_e state_r;
   logic [15:0] step_cnt_r;
   logic [2:0] trig_sync_r;
   logic wr_en;
   logic rd_en;
   logic sw_start;
   logic sw_stop;
   logic trig_edge;
   logic start_ev;
   logic tick;
   logic sar_load;
   logic sar_step_en;
   logic sar_last;
   logic conv_done;
   logic [W-1:0] sar_trial;
   logic [15:0] step_len;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && !penable && !pwrite;
   assign sw_start = wr_en && hit(paddr, OFF_START)
      && pwdata[START_FLAG_BIT];
   assign sw_stop = wr_en && hit(paddr, OFF_START)
      && !pwdata[START_FLAG_BIT];

   // ****************************************
   // Trigger synchroniser
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trig_sync_r <= 3'h0;
      else
         trig_sync_r <= {trig_sync_r[1:0], ext_trigger_pin};
   end

   // ****************************************
   // Trigger edge
   // ****************************************
   always_comb
   begin
      if (edge_select_reg_r[EDGE_TRIG_BIT])
         trig_edge = trig_sync_r[1] && !trig_sync_r[2];
      else
         trig_edge = !trig_sync_r[1] && trig_sync_r[2];
   end

   // ****************************************
   // Start event
   // ****************************************
   assign start_ev = sw_start || (trig_edge && mode_r.trig_en
      && port_mode_reg_one_r[PORT_TRIG_BIT]);

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= mode_s'(MODE_RST[5:0]);
         port_mode_reg_one_r <= PORT_MODE_RST;
         edge_select_reg_r <= EDGE_SEL_RST;
         conv_irq_enable_bit_r <= 1'b0;
      end
      else if (wr_en)
      begin
         if (hit(paddr, OFF_MODE))
         begin
            mode_r.channel <= pwdata[MODE_CH_LSB +: MODE_CH_W];
            mode_r.long_time <= pwdata[MODE_TIME_BIT];
            mode_r.trig_en <= pwdata[MODE_TRIGGER_ENABLE_BIT_BIT];
         end
         if (hit(paddr, OFF_PORT_MODE))
            port_mode_reg_one_r <= pwdata[7:0];
         if (hit(paddr, OFF_EDGE_SEL))
            edge_select_reg_r <= pwdata[7:0];
         if (hit(paddr, OFF_IRQ_EN))
            conv_irq_enable_bit_r <= pwdata[IRQ_CONV_BIT];
      end
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   assign step_len = mode_r.long_time ? STEP_LONG : STEP_SHORT;
   assign tick = (step_cnt_r == 16'h0001);
   assign sar_load = (state_r == ST_SAMPLE) && tick;
   assign sar_step_en = (state_r == ST_APPROX) && tick && !sw_stop;
   assign conv_done = sar_step_en && sar_last;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= ST_IDLE;
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (start_ev)
                  state_r <= ST_SAMPLE;
            end
            ST_SAMPLE, ST_APPROX:
            begin
               if (sw_stop)
                  state_r <= ST_IDLE;
               else if (tick)
               begin
                  if (state_r == ST_SAMPLE)
                     state_r <= ST_APPROX;
                  else if (sar_last)
                     state_r <= ST_IDLE;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Step counter
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         step_cnt_r <= 16'h0000;
      else if (state_r == ST_IDLE || tick)
         step_cnt_r <= step_len;
      else
         step_cnt_r <= step_cnt_r - 16'h0001;
   end

   sar_step #(.W(W)) u_sar
   (
      .pclk(pclk),
      .presetn(presetn),
      .load(sar_load),
      .step(sar_step_en),
      .cmp_hi(cmp_hi),
      .trial(sar_trial),
      .bit_mask(),
      .last(sar_last)
   );

   // ****************************************
   // Start flag
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conv_start_flag_r <= 1'b0;
      else if (start_ev && state_r == ST_IDLE)
         conv_start_flag_r <= 1'b1;
      else if (conv_done || sw_stop)
         conv_start_flag_r <= 1'b0;
   end

   // ****************************************
   // Conversion result
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_r <= '0;
      else if (conv_done)
         result_r <= cmp_hi ? sar_trial : (sar_trial & ~W'(1));
   end

   // ****************************************
   // Interrupt request flag
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conv_irq_request_flag_r <= 1'b0;
      else if (conv_done)
         conv_irq_request_flag_r <= 1'b1;
      else if (wr_en && hit(paddr, OFF_IRQ_REQ) && pwdata[IRQ_CONV_BIT])
         conv_irq_request_flag_r <= 1'b0;
   end

   // ****************************************
   // Interrupt line
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= conv_irq_request_flag_r && conv_irq_enable_bit_r;
   end

   // ****************************************
   // Analog outputs
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         channel_sel <= 4'h0;
         sample_en <= 1'b0;
         dac_trial <= '0;
      end
      else
      begin
         channel_sel <= mode_r.channel;
         sample_en <= (state_r == ST_SAMPLE);
         dac_trial <= sar_trial;
      end
   end

   // ****************************************
   // APB read and response
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (rd_en)
         begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
               OFF_MODE:
               begin
                  prdata[MODE_CH_LSB +: MODE_CH_W] <= mode_r.channel;
                  prdata[MODE_TIME_BIT] <= mode_r.long_time;
                  prdata[MODE_TRIGGER_ENABLE_BIT_BIT] <= mode_r.trig_en;
               end
               OFF_START: prdata[START_FLAG_BIT] <= conv_start_flag_r;
               OFF_RESULT: prdata[W-1:0] <= result_r;
               OFF_IRQ_REQ: prdata[IRQ_CONV_BIT] <= conv_irq_request_flag_r;
               OFF_IRQ_EN: prdata[IRQ_CONV_BIT] <= conv_irq_enable_bit_r;
               OFF_PORT_MODE: prdata[7:0] <= port_mode_reg_one_r;
               OFF_EDGE_SEL: prdata[7:0] <= edge_select_reg_r;
               default: pslverr <= psel && !penable;
            endcase
         end
      end
   end

endmodule

// ### sim/adc_conversion_control_sva.sv
`timescale 1ns/100ps
module adc_conversion_control_sva
   import adc_ctrl_pkg::*;
#(
   parameter int W = RESULT_W
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Front end and pins
   input wire logic cmp_hi,
   input wire logic [3:0] channel_sel,
   input wire logic sample_en,
   input wire logic [W-1:0] dac_trial,
   input wire logic ext_trigger_pin,
   input wire logic irq
);
   logic wr;
   assign wr = psel && penable && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_bad_rd;
      s_setup ##0 (!pwrite && paddr > OFF_EDGE_SEL);
   endsequence
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_ready_only;
      pready |-> $past(psel && !penable);
   endproperty
   property p_bad_rd;
      s_bad_rd |=> pslverr && prdata == 32'h0;
   endproperty
   property p_err_only;
      pslverr |-> pready;
   endproperty
   property p_chan;
      $changed(channel_sel) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
   endproperty
   property p_irq_fall;
      $fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
   endproperty
   property p_sample_len;
      $rose(sample_en) |-> ##[1:9] !sample_en;
   endproperty
   property p_trial_hold;
      sample_en && $past(sample_en) |-> $stable(dac_trial);
   endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   a_ready_only: assert property (p_ready_only) else $error("stray ready");
   a_bad_rd: assert property (p_bad_rd) else $error("no read error");
   a_err_only: assert property (p_err_only) else $error("stray error");
   a_chan: assert property (p_chan) else $error("channel moved");
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
   a_sample_len: assert property (p_sample_len)
      else $error("long sample");
   a_trial_hold: assert property (p_trial_hold)
      else $error("trial moved");
endmodule

// ### sim/adc_front_model.sv
`timescale 1ns/100ps
module adc_front_model
   import adc_ctrl_pkg::*;
(
   // Analog side
   input wire logic [RESULT_W-1:0] level,
   input wire logic [RESULT_W-1:0] dac_trial,
   output logic cmp_hi
);
   // Comparator keeps the trial bit at or below the input
   assign cmp_hi = (level >= dac_trial);
endmodule

// ### sim/adc_conversion_control_bench.sv
`timescale 1ns/100ps
module adc_conversion_control_bench
   import adc_ctrl_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_trigger_pin = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdat, prdata;
   logic pready, pslverr, cmp_hi, sample_en, irq, err, lt;
   logic [3:0] channel_sel, ch;
   logic [9:0] dac_trial, level = 10'h000;
   integer fails = 0, cmp_count = 0, cyc = 0, seed = 32'h1c00, i, k;
   integer slen = 0, scnt = 0;
   adc_conversion_control adc_conversion_control_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_hi(cmp_hi), .channel_sel(channel_sel),
      .sample_en(sample_en), .dac_trial(dac_trial),
      .ext_trigger_pin(ext_trigger_pin), .irq(irq));
   adc_front_model adc_front_model_i (.level(level), .dac_trial(dac_trial),
      .cmp_hi(cmp_hi));
   initial forever #4 pclk = ~pclk;
   function automatic logic [31:0] mode_w(input logic [3:0] c,
      input logic l, input logic t);
      return {26'h0, t, l, c};
   endfunction
   task automatic final_report;
      if (fails == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails = fails + 1;
         final_report();
      end
   end
   always @(posedge pclk)
   begin
      if (sample_en)
         scnt <= scnt + 1;
      else if (scnt != 0)
      begin
         slen <= scnt;
         scnt <= 0;
      end
   end
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
         fails = fails + 1;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_done;
      k = 0;
      bus(1'b0, OFF_START, 32'h0);
      while (rdat[START_FLAG_BIT] === 1'b1 && k < 80)
      begin
         bus(1'b0, OFF_START, 32'h0);
         k = k + 1;
      end
   endtask
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, OFF_MODE, 32'h0);
      chk("mode reset", 32'h0, rdat);
      bus(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      for (i = 0; i < 6; i++)
      begin
         level <= (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($random(seed));
         ch = 4'($random(seed));
         lt = i[0];
         bus(1'b1, OFF_IRQ_EN, {31'h0, i < 4});
         bus(1'b1, OFF_MODE, mode_w(ch, lt, 1'b0));
         bus(1'b0, OFF_MODE, 32'h0);
         chk("mode", mode_w(ch, lt, 1'b0), rdat);
         bus(1'b1, OFF_START, 32'h80);
         bus(1'b0, OFF_START, 32'h0);
         chk("flag busy", 32'h80, rdat);
         wait_done();
         chk("flag clear", 32'h0, rdat);
         chk("sample", lt ? 32'(STEP_LONG) : 32'(STEP_SHORT), slen);
         bus(1'b0, OFF_RESULT, 32'h0);
         chk("result", {22'h0, level}, rdat);
         chk("channel", {28'h0, ch}, {28'h0, channel_sel});
         bus(1'b0, OFF_IRQ_REQ, 32'h0);
         chk("irq flag", 32'h1, rdat);
         chk("irq line", {31'h0, i < 4}, {31'h0, irq});
         bus(1'b1, OFF_IRQ_REQ, 32'h1);
         repeat (2) @(posedge pclk);
         chk("irq clear", 32'h0, {31'h0, irq});
      end
      bus(1'b1, OFF_START, 32'h80);
      repeat (20) @(posedge pclk);
      bus(1'b1, OFF_START, 32'h0);
      repeat (120) @(posedge pclk);
      bus(1'b0, OFF_START, 32'h0);
      chk("abort flag", 32'h0, rdat);
      bus(1'b0, OFF_IRQ_REQ, 32'h0);
      chk("abort irq", 32'h0, rdat);
      for (i = 0; i < 4; i++)
      begin
         bus(1'b1, OFF_PORT_MODE, 32'h0);
         ext_trigger_pin <= (i == 0);
         bus(1'b1, OFF_MODE, mode_w(4'h1, 1'b0, i != 3));
         bus(1'b0, OFF_MODE, 32'h0);
         chk("trig mode", mode_w(4'h1, 1'b0, i != 3), rdat);
         bus(1'b1, OFF_EDGE_SEL, {31'h0, i != 0});
         bus(1'b1, OFF_PORT_MODE, {31'h0, i != 2});
         ext_trigger_pin <= (i != 0);
         repeat (6) @(posedge pclk);
         bus(1'b0, OFF_START, 32'h0);
         chk("trigger start", {24'h0, i < 2, 7'h0}, rdat);
         wait_done();
         chk("single start", 32'h0, rdat);
      end
      final_report();
   end
endmodule
bind adc_conversion_control adc_conversion_control_sva #(.W(W))
   adc_conversion_control_sva_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_hi(cmp_hi), .channel_sel(channel_sel),
      .sample_en(sample_en), .dac_trial(dac_trial),
      .ext_trigger_pin(ext_trigger_pin), .irq(irq));
